// *** logic/ascii_addressed_frame_codec.sv ***
`timescale 1ns/1ns
`include "frame_codec_map.svh"
module ascii_addressed_frame_codec #(
    parameter int PAYLOAD_DEPTH = `PAYLOAD_DEPTH
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire frame_codec_pkg::bcd_addr_t unit_id,
    input  wire logic                       menu_active,
    input  wire logic                       rx_valid,
    input  wire logic [7:0]                 rx_char,
    output logic                            frame_valid,
    output frame_codec_pkg::bcd_addr_t      frame_src,
    output logic [7:0]                      frame_len,
    output logic                            frame_rd_valid,
    output logic [7:0]                      frame_rd_char,
    input  wire logic                       frame_rd_ready,
    input  wire logic                       cmd_unknown,
    input  wire logic                       tx_start,
    input  wire frame_codec_pkg::bcd_addr_t tx_dest,
    input  wire logic                       tx_pay_valid,
    input  wire logic [7:0]                 tx_pay_char,
    input  wire logic                       tx_pay_last,
    output logic                            tx_pay_ready,
    output logic                            tx_busy,
    output logic                            tx_valid,
    output logic [7:0]                      tx_char,
    input  wire logic                       tx_ready
);
    import frame_codec_pkg::*;

    localparam int PW = $clog2(PAYLOAD_DEPTH);
    localparam logic [7:0] ERR0 = 8'h45;
    localparam logic [7:0] ERR1 = 8'h52;

    typedef struct packed {
        rx_state_e   rs;
        logic [2:0]  dig;
        bcd_addr_t   dst;
        bcd_addr_t   src;
        logic [7:0]  len;
        logic [7:0]  hold1;
        logic [7:0]  hold2;
        logic [PW:0] wr;
        logic [PW:0] rd;
        logic        ovf;
        logic        valid;
        bcd_addr_t   osrc;
        logic [7:0]  olen;
        tx_state_e   ts;
        logic [2:0]  tdig;
        bcd_addr_t   tdst;
        logic        terr;
        logic [1:0]  eidx;
    } st_s;

    st_s        q;
    st_s        d;
    logic [7:0] pay_mem [PAYLOAD_DEPTH];
    logic [6:0] rx_sum;
    logic [6:0] tx_sum;
    logic [7:0] rx_tens;
    logic [7:0] rx_ones;
    logic [7:0] tx_tens;
    logic [7:0] tx_ones;
    logic       rx_clr;
    logic       rx_add;
    logic       tx_clr;
    logic       tx_add;
    logic [7:0] rx_add_c;
    logic [7:0] tx_out_c;
    logic       is_digit;
    logic       pay_push;

    mod100_acc u_rx_sum (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clear   (rx_clr),
        .add_en  (rx_add),
        .add_char(rx_add_c),
        .sum_q   (rx_sum)
    );
    mod100_acc u_tx_sum (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clear   (tx_clr),
        .add_en  (tx_add),
        .add_char(tx_out_c),
        .sum_q   (tx_sum)
    );

    digit_pair u_rx_pair (
        .value    (rx_sum),
        .tens_char(rx_tens),
        .ones_char(rx_ones)
    );
    digit_pair u_tx_pair (
        .value    (tx_sum),
        .tens_char(tx_tens),
        .ones_char(tx_ones)
    );

    function automatic logic [7:0] nib_chr(input logic [3:0] n);
        nib_chr = `ASCII_ZERO + {4'h0, n};
    endfunction : nib_chr

    always_comb begin
        d        = q;
        rx_clr   = 1'b0;
        rx_add   = 1'b0;
        rx_add_c = 8'h00;
        pay_push = 1'b0;
        tx_clr   = 1'b0;
        tx_add   = 1'b0;
        tx_out_c = 8'h00;
        is_digit = (rx_char >= `ASCII_ZERO) && (rx_char <= `ASCII_NINE);
        d.valid  = 1'b0;
        if (frame_rd_valid && frame_rd_ready) begin
            d.rd = q.rd + (PW+1)'(1);
        end
        // receiver
        if (rx_valid && menu_active) begin
            d.rs = RX_IDLE;
            d.rd = '0;
            d.wr = '0;
        end else if (rx_valid && rx_char == `ATTENTION_CHAR) begin
            d.rs  = RX_DEST;
            d.dig = 3'h0;
            d.len = 8'h01;
            d.rd  = '0;
            d.wr  = '0;
            rx_clr = 1'b1;
        end else if (rx_valid) begin
            d.len = q.len + 8'h01;
            case (q.rs)
                RX_DEST, RX_RETURN: begin
                    if (!is_digit) begin
                        d.rs = RX_IDLE;
                    end else begin
                        rx_add   = 1'b1;
                        rx_add_c = rx_char;
                        if (q.rs == RX_DEST) begin
                            d.dst = {q.dst[11:0], rx_char[3:0]};
                        end else begin
                            d.src = {q.src[11:0], rx_char[3:0]};
                        end
                        d.dig = q.dig + 3'h1;
                        if (q.dig == `ADDR_DIGITS - 3'h1) begin
                            d.dig = 3'h0;
                            d.rs  = (q.rs == RX_DEST) ? RX_RETURN : RX_BODY;
                            d.wr  = '0;
                            d.ovf = 1'b0;
                        end
                    end
                end
                RX_BODY: begin
                    if (rx_char == `END_TEXT_CHAR) begin
                        d.rs = RX_IDLE;
                        d.wr = '0;
                        if (d.len >= `MIN_FRAME_LEN && !q.ovf
                            && q.hold1 == rx_tens && q.hold2 == rx_ones
                            && (q.dst == unit_id || q.dst == `UNIVERSAL_ADDR)) begin
                            d.valid = 1'b1;
                            d.osrc  = q.src;
                            d.olen  = q.len - 8'h0b;
                            d.rd    = '0;
                            d.wr    = q.wr - (PW+1)'(2);
                        end
                    end else begin
                        // last two characters stay held until they prove not to be the sum
                        if (q.len >= 8'h0b) begin
                            rx_add   = 1'b1;
                            rx_add_c = q.hold1;
                        end
                        d.hold1 = q.hold2;
                        d.hold2 = rx_char;
                        if (q.wr == (PW+1)'(PAYLOAD_DEPTH)) begin
                            d.ovf = 1'b1;
                        end else begin
                            pay_push = 1'b1;
                            d.wr = q.wr + (PW+1)'(1);
                        end
                    end
                end
                default: d.rs = RX_IDLE;
            endcase
        end

        // transmitter
        case (q.ts)
            TX_IDLE: begin
                if (q.valid && cmd_unknown) begin
                    d.ts   = TX_ATTN;
                    d.tdst = q.osrc;
                    d.terr = 1'b1;
                end else if (tx_start) begin
                    d.ts   = TX_ATTN;
                    d.tdst = tx_dest;
                    d.terr = 1'b0;
                end
                d.tdig = 3'h0;
                d.eidx = 2'h0;
                tx_clr = 1'b1;
            end
            TX_ATTN: tx_out_c = `ATTENTION_CHAR;
            TX_DEST: tx_out_c = nib_chr(q.tdst[15-4*q.tdig -: 4]);
            TX_RETURN: tx_out_c = nib_chr(unit_id[15-4*q.tdig -: 4]);
            TX_BODY: tx_out_c = q.terr ? (q.eidx == 2'h0 ? ERR0 : ERR1) : tx_pay_char;
            TX_SUM_HI: tx_out_c = tx_tens;
            TX_SUM_LO: tx_out_c = tx_ones;
            TX_END: tx_out_c = `END_TEXT_CHAR;
            default: d.ts = TX_IDLE;
        endcase
        tx_valid     = (q.ts != TX_IDLE) && (q.ts != TX_BODY || q.terr || tx_pay_valid);
        tx_pay_ready = (q.ts == TX_BODY) && !q.terr && tx_ready;
        if (tx_valid && tx_ready) begin
            case (q.ts)
                TX_ATTN: d.ts = TX_DEST;
                TX_DEST, TX_RETURN: begin
                    tx_add = 1'b1;
                    d.tdig = q.tdig + 3'h1;
                    if (q.tdig == `ADDR_DIGITS - 3'h1) begin
                        d.tdig = 3'h0;
                        d.ts = (q.ts == TX_DEST) ? TX_RETURN : TX_BODY;
                    end
                end
                TX_BODY: begin
                    tx_add = 1'b1;
                    d.eidx = q.eidx + 2'h1;
                    if (q.terr ? (q.eidx == 2'h1) : tx_pay_last) begin
                        d.ts = TX_SUM_HI;
                    end
                end
                TX_SUM_HI: d.ts = TX_SUM_LO;
                TX_SUM_LO: d.ts = TX_END;
                TX_END: d.ts = TX_IDLE;
                default: d.ts = TX_IDLE;
            endcase
        end
        if (q.terr && q.ts == TX_BODY && q.eidx == 2'h1) begin
            tx_out_c = ERR1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= '{rs: RX_IDLE, ts: TX_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    // payload store
    always_ff @(posedge ref_clk) begin
        if (pay_push) begin
            pay_mem[q.wr[PW-1:0]] <= rx_char;
        end
    end

    assign frame_valid    = q.valid;
    assign frame_src      = q.osrc;
    assign frame_len      = q.olen;
    assign frame_rd_valid = (q.rd != q.wr) && (q.rs == RX_IDLE);
    assign frame_rd_char  = frame_rd_valid ? pay_mem[q.rd[PW-1:0]] : 8'h00;
    assign tx_busy        = (q.ts != TX_IDLE);
    assign tx_char        = tx_out_c;
endmodule : ascii_addressed_frame_codec

// splits a value below 100 into two ascii decimal digits, tens first
module digit_pair (
    input  wire logic [6:0] value,
    output logic      [7:0] tens_char,
    output logic      [7:0] ones_char
);
    logic [6:0] tens;
    logic [6:0] ones;
    always_comb begin
        tens      = value / 7'h0a;
        ones      = value - (tens * 7'h0a);
        tens_char = `ASCII_ZERO + {1'h0, tens};
        ones_char = `ASCII_ZERO + {1'h0, ones};
    end
endmodule : digit_pair

// *** logic/frame_codec_map.svh ***
`ifndef FRAME_CODEC_MAP_SVH
`define FRAME_CODEC_MAP_SVH
`define ATTENTION_CHAR   8'h23
`define END_TEXT_CHAR    8'h03
`define ASCII_ZERO       8'h30
`define ASCII_NINE       8'h39
`define UNIVERSAL_ADDR   16'h9999
`define ADDR_DIGITS      3'h4
`define MIN_FRAME_LEN    8'h0d
`define CHECK_MOD        7'h64
`define PAYLOAD_DEPTH    64
`endif

// *** logic/frame_codec_pkg.sv ***
package frame_codec_pkg;
    typedef enum logic [2:0] {
        RX_IDLE, RX_DEST, RX_RETURN, RX_BODY, RX_DONE
    } rx_state_e;
    typedef enum logic [2:0] {
        TX_IDLE, TX_ATTN, TX_DEST, TX_RETURN, TX_BODY, TX_SUM_HI, TX_SUM_LO, TX_END
    } tx_state_e;
    typedef logic [15:0] bcd_addr_t;
endpackage : frame_codec_pkg

// *** logic/mod100_acc.sv ***
`timescale 1ns/1ns
`include "frame_codec_map.svh"
// running sum of character codes kept modulo 100
module mod100_acc (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       add_en,
    input  wire logic [7:0] add_char,
    output logic      [6:0] sum_q
);
    logic [8:0] raw;
    logic [8:0] red1;
    logic [8:0] red2;
    always_comb begin
        raw  = {2'h0, sum_q} + {1'h0, add_char};
        red1 = (raw  >= 9'h0c8) ? raw  - 9'h0c8 : raw;
        red2 = (red1 >= 9'h064) ? red1 - 9'h064 : red1;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n || clear) begin
            sum_q <= 7'h00;
        end else if (add_en) begin
            sum_q <= red2[6:0];
        end
    end
endmodule : mod100_acc

// *** verif/frame_codec_properties.sv ***
`timescale 1ns/1ns
module frame_codec_properties #(
    parameter int PAYLOAD_DEPTH = 64
) (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       menu_active,
    input wire logic                       rx_valid,
    input wire logic [7:0]                 rx_char,
    input wire logic                       frame_valid,
    input wire frame_codec_pkg::bcd_addr_t frame_src,
    input wire logic [7:0]                 frame_len,
    input wire logic                       tx_start,
    input wire logic                       tx_busy,
    input wire logic                       tx_valid,
    input wire logic [7:0]                 tx_char,
    input wire logic                       tx_ready
);
    import frame_codec_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence start_in; tx_start && !tx_busy; endsequence
    sequence held_out; tx_valid && !tx_ready; endsequence
    chk_valid_pulse: assert property (
        frame_valid |=> !frame_valid) else $error("accept pulse too long");
    chk_valid_etx: assert property (
        frame_valid |-> $past(rx_valid) && $past(rx_char) == 8'h03)
        else $error("accept without end code");
    chk_menu_ignore: assert property (
        menu_active |=> !frame_valid) else $error("accept while menu active");
    chk_len_nonzero: assert property (
        frame_valid |-> frame_len != 8'h00) else $error("empty payload accepted");
    chk_src_digits: assert property (
        frame_valid |-> frame_src[15:12] <= 4'h9 && frame_src[11:8] <= 4'h9
        && frame_src[7:4] <= 4'h9 && frame_src[3:0] <= 4'h9)
        else $error("return address not decimal");
    chk_src_hold: assert property (
        !frame_valid |=> $stable(frame_src) || frame_valid)
        else $error("return address changed");
    chk_tx_attn: assert property (
        start_in |=> tx_busy && tx_valid && tx_char == 8'h23)
        else $error("frame did not open with attention");
    chk_char_hold: assert property (
        held_out |=> tx_valid && $stable(tx_char)) else $error("tx char dropped");
    chk_idle_quiet: assert property (
        !tx_busy |-> !tx_valid) else $error("tx char while idle");
endmodule : frame_codec_properties

// *** verif/host_model.sv ***
`timescale 1ns/1ns
module host_model (
    input  wire logic       ref_clk,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_char,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_char
);
    logic [7:0] got[$];
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_char = 8'h00;
    end
    always @(posedge ref_clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_char);
    end
    // one character per cycle, line shows inverse of last after frame
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            rx_char <= s[i];
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_char <= ~s[s.len()-1];
    endtask : send
endmodule : host_model

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
    import frame_codec_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic menu_active = 1'b0, cmd_unknown = 1'b0, frame_rd_ready = 1'b0;
    logic tx_start = 1'b0, tx_pay_valid = 1'b0, tx_pay_last = 1'b0;
    bcd_addr_t unit_id = 16'h1025, tx_dest = 16'h0000, frame_src;
    logic [7:0] tx_pay_char = 8'h00, frame_len, frame_rd_char, tx_char, rx_char;
    logic frame_valid, frame_rd_valid, tx_pay_ready, tx_busy, tx_valid, tx_ready, rx_valid;
    int fails = 0, comparisons = 0, hits = 0;
    logic [7:0] rd_q[$];
    always #20 ref_clk = ~ref_clk;
    ascii_addressed_frame_codec DUT (.ref_clk, .rst_n, .unit_id, .menu_active, .rx_valid,
        .rx_char, .frame_valid, .frame_src, .frame_len, .frame_rd_valid, .frame_rd_char,
        .frame_rd_ready, .cmd_unknown, .tx_start, .tx_dest, .tx_pay_valid, .tx_pay_char,
        .tx_pay_last, .tx_pay_ready, .tx_busy, .tx_valid, .tx_char, .tx_ready);
    host_model host (.ref_clk, .slow, .tx_valid, .tx_char, .tx_ready, .rx_valid, .rx_char);
    always @(posedge ref_clk) begin
        if (frame_valid === 1'b1) begin
            hits++;
            rd_q.delete();
        end
        if (frame_rd_valid === 1'b1 && frame_rd_ready) rd_q.push_back(frame_rd_char);
    end
    function automatic string frame(string d, string s, string p, int bias);
        string m = {d, s, p};
        int c = bias;
        foreach (m[i]) c += m[i];
        return $sformatf("#%s%02d%c", m, c % 100, 8'h03);
    endfunction : frame
    function automatic string q2s(logic [7:0] q[$]);
        string s = "";
        foreach (q[i]) s = $sformatf("%s%c", s, q[i]);
        return s;
    endfunction : q2s
    task automatic cmp_val(string nm, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_val
    task automatic cmp_str(string nm, string e, string g);
        comparisons++;
        if (g != e) begin
            fails++;
            $display("CHECK FAILED %s expected %s seen %s", nm, e, g);
        end
    endtask : cmp_str
    task automatic rx_case(string nm, string f, int exp);
        int h0 = hits;
        host.send(f);
        repeat (8) @(posedge ref_clk);
        cmp_val(nm, 16'(exp), 16'(hits - h0));
    endtask : rx_case
    task automatic wait_idle();
        for (int n = 0; n < 400 && tx_busy !== 1'b0; n++) @(posedge ref_clk);
    endtask : wait_idle
    task automatic t_accept();
        rx_case("own", frame("1025", "0100", "DL5", 0), 1);
        cmp_val("src", 16'h0100, frame_src);
        cmp_val("len", 16'h0003, {8'h00, frame_len});
        cmp_str("payload", "DL5", q2s(rd_q));
        $display("test accept done");
    endtask : t_accept
    task automatic t_universal();
        unit_id <= 16'h0007;
        rx_case("universal", frame("9999", "0100", "X", 0), 1);
        rx_case("old_id", frame("1025", "0100", "X", 0), 0);
        unit_id <= 16'h1025;
        $display("test universal done");
    endtask : t_universal
    task automatic t_drops();
        rx_case("bad_sum", frame("1025", "0100", "DL5", 1), 0);
        rx_case("wrong_dest", frame("1024", "0100", "DL5", 0), 0);
        rx_case("bad_digit", frame("1A25", "0100", "DL5", 0), 0);
        rx_case("short", frame("1025", "0100", "", 0), 0);
        menu_active <= 1'b1;
        rx_case("menu", frame("1025", "0100", "DL5", 0), 0);
        menu_active <= 1'b0;
        cmp_str("stale_read", "X", q2s(rd_q));
        rx_case("restart", {"#1025", frame("1025", "0100", "Q", 0)}, 1);
        $display("test drops done");
    endtask : t_drops
    task automatic t_err();
        slow <= 1'b1;
        cmd_unknown <= 1'b1;
        host.got.delete();
        rx_case("err_accept", frame("1025", "0100", "ZZ", 0), 1);
        cmd_unknown <= 1'b0;
        wait_idle();
        cmp_str("err_reply", frame("0100", "1025", "ER", 0), q2s(host.got));
        $display("test error reply done");
    endtask : t_err
    task automatic t_tx();
        host.got.delete();
        tx_dest <= 16'h0042;
        tx_pay_char <= 8'h66;
        tx_pay_valid <= 1'b1;
        tx_pay_last <= 1'b1;
        tx_start <= 1'b1;
        @(posedge ref_clk);
        tx_start <= 1'b0;
        for (int n = 0; n < 200 && tx_pay_ready !== 1'b1; n++) @(posedge ref_clk);
        tx_pay_valid <= 1'b0;
        tx_pay_last <= 1'b0;
        @(posedge ref_clk);
        wait_idle();
        cmp_str("tx_frame", frame("0042", "1025", "f", 0), q2s(host.got));
        $display("test transmit done");
    endtask : t_tx
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        frame_rd_ready <= 1'b1;
        t_accept();
        t_universal();
        t_drops();
        t_err();
        t_tx();
        tally_and_finish();
    end
    initial begin
        #(40 * 20000);
        fails++;
        tally_and_finish();
    end
endmodule : tb
bind ascii_addressed_frame_codec frame_codec_properties #(.PAYLOAD_DEPTH(PAYLOAD_DEPTH)) chk (
    .ref_clk, .rst_n, .menu_active, .rx_valid, .rx_char, .frame_valid, .frame_src,
    .frame_len, .tx_start, .tx_busy, .tx_valid, .tx_char, .tx_ready);
